/* File: rtl/eac_pkg.sv */
// Constants and types for the EEPROM access control block
package eac_pkg;
    // I/O window and bit-access range
    localparam logic [7:0] IO_TOP       = 8'h3F;
    localparam logic [7:0] BIT_TOP      = 8'h1F;
    localparam logic [7:0] DS_OFFSET    = 8'h20;
    localparam logic [7:0] DS_TOP       = 8'h5F;
    // Register offsets in I/O space
    localparam logic [5:0] OFS_CONTROL  = 6'h1C;
    localparam logic [5:0] OFS_DATA     = 6'h1D;
    localparam logic [5:0] OFS_ADDR_LO  = 6'h1E;
    localparam logic [5:0] OFS_ADDR_HI  = 6'h1F;
    // Control field positions
    localparam int BIT_READ_STROBE      = 0;
    localparam int BIT_PROG_TRIGGER     = 1;
    localparam int BIT_MASTER_ARM       = 2;
    localparam int BIT_READY_IRQ_EN     = 3;
    localparam int BIT_MODE_LO          = 4;
    localparam int BIT_MODE_HI          = 5;
    localparam int BIT_ADDR8            = 0;
    // Programming modes
    localparam logic [1:0] MODE_ATOMIC  = 2'h0;
    localparam logic [1:0] MODE_ERASE   = 2'h1;
    localparam logic [1:0] MODE_WRITE   = 2'h2;
    localparam logic [1:0] MODE_RSVD    = 2'h3;
    // Reset values
    localparam logic [1:0] MODE_RST     = 2'h0;
    localparam logic [7:0] DATA_RST     = 8'h00;
    localparam logic [8:0] ADDR_RST     = 9'h000;
    // Core-clock cycle counts
    localparam logic [2:0] ARM_CYCLES   = 3'h4;
    localparam logic [2:0] STALL_PROG   = 3'h2;
    localparam logic [2:0] STALL_READ   = 3'h4;
    // Programming times in tenths of microseconds, timed on the calibrated oscillator
    localparam int OSC_MHZ              = 8;
    localparam int T_ATOMIC_US_X10      = 34000;
    localparam int T_SPLIT_US_X10       = 18000;
    localparam int TICKS_ATOMIC         = T_ATOMIC_US_X10 * OSC_MHZ / 10;
    localparam int TICKS_SPLIT          = T_SPLIT_US_X10 * OSC_MHZ / 10;
    localparam int TMR_W                = 16;
    localparam logic [TMR_W-1:0] TMR_ONE = 16'h0001;

    typedef enum logic [1:0] {
        EAC_IDLE = 2'b01,
        EAC_PROG = 2'b10
    } eac_state_e_t;

    typedef struct packed {
        eac_state_e_t     st;
        logic [1:0]       mode;
        logic             rie;
        logic             mpe;
        logic [2:0]       arm_cnt;
        logic [8:0]       addr;
        logic [7:0]       data;
        logic [TMR_W-1:0] tmr;
        logic [2:0]       stall_cnt;
        logic             stall;
        logic             irq;
        logic [7:0]       rdata;
        logic             hit;
        logic             mem_rd;
        logic             rd_cap;
        logic             erase;
        logic             write;
        logic [7:0]       wbyte;
    } eac_regs_t;
endpackage

/* File: rtl/eac_top.sv */
// EEPROM access control: I/O registers, program sequencing and read path
`timescale 1ns/100ps

// Notes on behaviour
// - Registers answer at I/O 0x1C-0x1F and data space 0x20 higher.
// - Bit set/clear on 0x00-0x1F touches only the addressed bit.
// - Byte address is nine bits; high register shows only bit 8.
// - Data register resets to zero; holds program byte or read result.
// - Mode 00 atomic 3.4 ms, 01 erase 1.8 ms, 10 write 1.8 ms.
// - Mode field writes are ignored while programming is busy.
// - Reset returns mode to 00 unless programming is in progress.
// - Level interrupt while ready, enabled locally and globally.
// - Master arm bit self-clears four cycles after being written.
// - Program trigger acts only while master arm is still set.
// - Trigger bit reads busy until the programming time elapses.
// - Starting programming stalls the core for two cycles.
// - Read strobe fetches the byte and stalls the core four cycles.
// - No reads and no address change while programming.
// - Programming time counts calibrated oscillator ticks.
// - Reset during programming does not abort the operation.
module eac_top #(
    parameter int TICKS_ATOMIC = eac_pkg::TICKS_ATOMIC,
    parameter int TICKS_SPLIT  = eac_pkg::TICKS_SPLIT
) (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic [7:0] bus_addr,
    input  wire logic       bus_data_space,
    input  wire logic       bus_wr,
    input  wire logic       bus_rd,
    input  wire logic       bus_bit_op,
    input  wire logic [2:0] bus_bit_idx,
    input  wire logic [7:0] bus_wdata,
    input  wire logic       global_irq_en,
    input  wire logic       osc_tick,
    input  wire logic [7:0] mem_rdata,
    output logic      [7:0] bus_rdata,
    output logic            bus_hit,
    output logic            core_stall,
    output logic            ready_irq,
    output logic            mem_rd,
    output logic      [8:0] mem_addr,
    output logic            mem_erase,
    output logic            mem_write,
    output logic      [7:0] mem_wbyte
);

    ////////////////////////////////////////////////////////////////////
    // Helpers

    // Map either address form onto the six-bit I/O index
    function automatic logic map_io(input logic [7:0] a, input logic ds,
                                    output logic [5:0] idx);
        logic [7:0] t;
        t = ds ? 8'(a - eac_pkg::DS_OFFSET) : a;
        idx = t[5:0];
        if (ds) begin
            return (a >= eac_pkg::DS_OFFSET) && (a <= eac_pkg::DS_TOP);
        end
        return a <= eac_pkg::IO_TOP;
    endfunction

    function automatic logic [7:0] ctrl_view(input eac_pkg::eac_regs_t s);
        logic [7:0] v;
        v = 8'h00;
        v[eac_pkg::BIT_MODE_HI]      = s.mode[1];
        v[eac_pkg::BIT_MODE_LO]      = s.mode[0];
        v[eac_pkg::BIT_READY_IRQ_EN] = s.rie;
        v[eac_pkg::BIT_MASTER_ARM]   = s.mpe;
        v[eac_pkg::BIT_PROG_TRIGGER] = (s.st == eac_pkg::EAC_PROG);
        return v;
    endfunction

    // Masked merge for byte and bit-op writes
    function automatic logic [7:0] merge_bits(input logic [7:0] old, input logic [7:0] val,
                                              input logic [7:0] mask);
        return (old & ~mask) | (val & mask);
    endfunction

    // Only the four access registers answer a read
    function automatic logic reg_window(input logic [5:0] idx);
        return (idx >= eac_pkg::OFS_CONTROL) && (idx <= eac_pkg::OFS_ADDR_HI);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // State

    eac_pkg::eac_regs_t r_q;
    eac_pkg::eac_regs_t r_d;

    logic       io_ok;
    logic [5:0] io_idx;
    logic       do_wr;
    logic [7:0] wmask;
    logic [7:0] wval;
    logic       busy;
    logic       start;
    logic [eac_pkg::TMR_W-1:0] load_ticks;

    always_comb begin
        r_d = r_q;
        // Shared decode
        io_ok = map_io(bus_addr, bus_data_space, io_idx);
        busy  = (r_q.st == eac_pkg::EAC_PROG);
        // single bit
        // Bit ops carry a one-hot mask so other write-one flags stay put
        wmask = bus_bit_op ? (8'h01 << bus_bit_idx) : 8'hFF;
        wval  = bus_wdata;
        do_wr = bus_wr && io_ok &&
                (!bus_bit_op || ({2'b00, io_idx} <= eac_pkg::BIT_TOP));
        start = 1'b0;
        load_ticks = eac_pkg::TMR_W'(TICKS_SPLIT);
        r_d.mem_rd = 1'b0;
        r_d.rd_cap = r_q.mem_rd;

        // Window closes on its own so a late stray trigger does nothing
        // arm timeout
        if (r_q.mpe) begin
            if (r_q.arm_cnt == 3'h0) begin
                r_d.mpe = 1'b0;
            end else begin
                r_d.arm_cnt = r_q.arm_cnt - 3'h1;
            end
        end

        if (r_q.rd_cap) begin
            r_d.data = mem_rdata;
        end

        if (do_wr) begin
            case (io_idx)
                eac_pkg::OFS_CONTROL: begin
                    if (!busy) begin
                        if (wmask[eac_pkg::BIT_MODE_HI]) begin
                            r_d.mode[1] = wval[eac_pkg::BIT_MODE_HI];
                        end
                        if (wmask[eac_pkg::BIT_MODE_LO]) begin
                            r_d.mode[0] = wval[eac_pkg::BIT_MODE_LO];
                        end
                    end
                    if (wmask[eac_pkg::BIT_READY_IRQ_EN]) begin
                        r_d.rie = wval[eac_pkg::BIT_READY_IRQ_EN];
                    end
                    if (wmask[eac_pkg::BIT_PROG_TRIGGER] &&
                        wval[eac_pkg::BIT_PROG_TRIGGER] && r_q.mpe && !busy &&
                        r_q.mode != eac_pkg::MODE_RSVD) begin
                        start = 1'b1;
                    end
                    if (wmask[eac_pkg::BIT_MASTER_ARM]) begin
                        if (wval[eac_pkg::BIT_MASTER_ARM]) begin
                            r_d.mpe     = 1'b1;
                            r_d.arm_cnt = eac_pkg::ARM_CYCLES - 3'h1;
                        end else begin
                            r_d.mpe = 1'b0;
                        end
                    end
                    // A trigger in the same write wins; no read beside programming
                    // read strobe
                    if (wmask[eac_pkg::BIT_READ_STROBE] &&
                        wval[eac_pkg::BIT_READ_STROBE] &&
                        !busy && !start) begin
                        r_d.mem_rd    = 1'b1;
                        r_d.stall_cnt = eac_pkg::STALL_READ;
                    end
                end
                eac_pkg::OFS_DATA: begin
                    r_d.data = merge_bits(r_q.data, wval, wmask);
                end
                eac_pkg::OFS_ADDR_LO: begin
                    if (!busy) begin
                        r_d.addr[7:0] = merge_bits(r_q.addr[7:0], wval, wmask);
                    end
                end
                eac_pkg::OFS_ADDR_HI: begin
                    if (!busy && wmask[eac_pkg::BIT_ADDR8]) begin
                        r_d.addr[8] = wval[eac_pkg::BIT_ADDR8];
                    end
                end
                default: begin
                end
            endcase
        end

        // Erase-only and write-only share the shorter time
        // mode timing
        if (r_q.mode == eac_pkg::MODE_ATOMIC) begin
            load_ticks = eac_pkg::TMR_W'(TICKS_ATOMIC);
        end

        case (r_q.st)
            eac_pkg::EAC_IDLE: begin
                if (start) begin
                    r_d.st        = eac_pkg::EAC_PROG;
                    r_d.tmr       = load_ticks;
                    r_d.mpe       = 1'b0;
                    r_d.wbyte     = r_q.data;
                    r_d.erase     = r_q.mode != eac_pkg::MODE_WRITE;
                    r_d.write     = r_q.mode != eac_pkg::MODE_ERASE;
                    r_d.stall_cnt = eac_pkg::STALL_PROG;
                end
            end
            eac_pkg::EAC_PROG: begin
                // Core clock speed does not change the programming time
                // oscillator timed
                if (osc_tick) begin
                    if (r_q.tmr <= eac_pkg::TMR_ONE) begin
                        r_d.st    = eac_pkg::EAC_IDLE;
                        r_d.erase = 1'b0;
                        r_d.write = 1'b0;
                        r_d.tmr   = '0;
                    end else begin
                        r_d.tmr = r_q.tmr - eac_pkg::TMR_ONE;
                    end
                end
            end
            default: begin
                r_d.st = eac_pkg::EAC_IDLE;
            end
        endcase

        // Stall counter; the loaded value stands as the first stall cycle
        if (r_d.stall_cnt == r_q.stall_cnt && r_q.stall_cnt != 3'h0) begin
            r_d.stall_cnt = r_q.stall_cnt - 3'h1;
        end
        r_d.stall = (r_d.stall_cnt != 3'h0);

        // Register read path, one cycle latency
        r_d.hit   = bus_rd && io_ok && reg_window(io_idx);
        r_d.rdata = 8'h00;
        if (bus_rd && io_ok) begin
            case (io_idx)
                eac_pkg::OFS_CONTROL: r_d.rdata = ctrl_view(r_q);
                eac_pkg::OFS_DATA:    r_d.rdata = r_q.data;
                eac_pkg::OFS_ADDR_LO: r_d.rdata = r_q.addr[7:0];
                eac_pkg::OFS_ADDR_HI: r_d.rdata = {7'h00, r_q.addr[8]};
                default:              r_d.rdata = 8'h00;
            endcase
        end

        // Held while ready; masked here with the core's global enable
        // level interrupt
        r_d.irq = r_d.rie && global_irq_en && (r_d.st == eac_pkg::EAC_IDLE);

        if (reset) begin
            r_d.rie       = 1'b0;
            r_d.mpe       = 1'b0;
            r_d.arm_cnt   = 3'h0;
            r_d.data      = eac_pkg::DATA_RST;
            r_d.stall_cnt = 3'h0;
            r_d.stall     = 1'b0;
            r_d.irq       = 1'b0;
            r_d.rdata     = 8'h00;
            r_d.hit       = 1'b0;
            r_d.mem_rd    = 1'b0;
            r_d.rd_cap    = 1'b0;
            // A running operation keeps state so no cell is left half done
            if (r_q.st != eac_pkg::EAC_PROG) begin
                r_d.st    = eac_pkg::EAC_IDLE;
                r_d.mode  = eac_pkg::MODE_RST;
                r_d.addr  = eac_pkg::ADDR_RST;
                r_d.tmr   = '0;
                r_d.erase = 1'b0;
                r_d.write = 1'b0;
                r_d.wbyte = 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registers and outputs

    always_ff @(posedge ref_clk) begin
        r_q <= r_d;
    end

    assign bus_rdata  = r_q.rdata;
    assign bus_hit    = r_q.hit;
    assign core_stall = r_q.stall;
    assign ready_irq  = r_q.irq;
    assign mem_rd     = r_q.mem_rd;
    assign mem_addr   = r_q.addr;
    assign mem_erase  = r_q.erase;
    assign mem_write  = r_q.write;
    assign mem_wbyte  = r_q.wbyte;

endmodule

/* File: tb/eac_array_model.sv */
// Behavioural EEPROM array and calibrated oscillator tick source
`timescale 1ns/100ps
module eac_array_model (
    input  wire logic       ref_clk,
    input  wire logic       mem_rd,
    input  wire logic [8:0] mem_addr,
    input  wire logic       mem_erase,
    input  wire logic       mem_write,
    input  wire logic [7:0] mem_wbyte,
    output logic            osc_tick,
    output logic      [7:0] mem_rdata
);
    logic [7:0] cells [0:511];
    logic [1:0] div_q = 2'h0;
    logic       prog_q = 1'b0;
    initial begin
        osc_tick = 1'b0;
        mem_rdata = 8'h00;
        for (int i = 0; i < 512; i++) begin
            cells[i] = 8'(i) ^ 8'hA5 ^ {7'h00, i[8]};
        end
    end
    always @(posedge ref_clk) begin
        div_q <= div_q + 2'h1;
        osc_tick <= (div_q == 2'h3);
        prog_q <= mem_erase | mem_write;
        // Stale data inverted so a late sample cannot pass by luck
        mem_rdata <= mem_rd ? cells[mem_addr] : ~mem_rdata;
        // erase leaves all ones, write stores the byte
        if (!prog_q && (mem_erase | mem_write)) begin
            cells[mem_addr] <= mem_write ? mem_wbyte : 8'hFF;
        end
    end
endmodule

/* File: tb/eac_props.sv */
// Assertion checker for the EEPROM access control block
`timescale 1ns/100ps
module eac_props (
    input wire logic       ref_clk,
    input wire logic       reset,
    input wire logic [7:0] bus_addr,
    input wire logic       bus_data_space,
    input wire logic       bus_rd,
    input wire logic       global_irq_en,
    input wire logic [7:0] bus_rdata,
    input wire logic       bus_hit,
    input wire logic       core_stall,
    input wire logic       ready_irq,
    input wire logic       mem_rd,
    input wire logic [8:0] mem_addr,
    input wire logic       mem_erase,
    input wire logic       mem_write,
    input wire logic [7:0] mem_wbyte
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire logic busy = mem_erase | mem_write;
    // Either address form of 0x1C-0x1F
    wire logic in_win = bus_data_space ? (bus_addr[7:2] == 6'h0F) : (bus_addr[7:2] == 6'h07);
    ////////////////////////////////////////////////////////////////////////////////
    a_read_stall_len: assert property ($rose(mem_rd) |-> core_stall [*4] ##1 !core_stall)
        else $error("read stall length wrong");
    a_read_one_pulse: assert property (mem_rd |=> !mem_rd)
        else $error("array read longer than one cycle");
    a_prog_stall_len: assert property ($rose(busy) |-> core_stall [*2] ##1 !core_stall)
        else $error("program stall length wrong");
    a_busy_no_read: assert property (busy |-> !mem_rd)
        else $error("array read while programming");
    a_irq_gating: assert property ((busy || !$past(global_irq_en)) |-> !ready_irq)
        else $error("ready request while busy or masked");
    a_hit_decode: assert property (bus_hit == $past(bus_rd && in_win))
        else $error("read answer does not follow decode");
    a_rdata_quiet: assert property (!bus_hit |-> bus_rdata == 8'h00)
        else $error("read data without a hit");
    a_prog_hold: assert property (busy && $past(busy) |-> $stable(mem_addr) && $stable(mem_wbyte))
        else $error("address or byte moved while programming");
endmodule
bind eac_top eac_props i_eac_props (.ref_clk, .reset, .bus_addr, .bus_data_space, .bus_rd,
    .global_irq_en, .bus_rdata, .bus_hit, .core_stall, .ready_irq, .mem_rd, .mem_addr,
    .mem_erase, .mem_write, .mem_wbyte);

/* File: tb/tb_eac_top.sv */
// Self-checking testbench for the EEPROM access control block
`timescale 1ns/100ps
module tb_eac_top;
    localparam int TA = 20;
    localparam int TS = 10;
    logic       ref_clk = 1'b0;
    logic       reset = 1'b1;
    logic [7:0] bus_addr = 8'h00;
    logic       bus_data_space = 1'b0;
    logic       bus_wr = 1'b0;
    logic       bus_rd = 1'b0;
    logic       bus_bit_op = 1'b0;
    logic [2:0] bus_bit_idx = 3'h0;
    logic [7:0] bus_wdata = 8'h00;
    logic       global_irq_en = 1'b0;
    logic       osc_tick, bus_hit, core_stall, ready_irq, mem_rd, mem_erase, mem_write;
    logic [7:0] mem_rdata, bus_rdata, mem_wbyte, dat;
    logic [8:0] mem_addr, adr;
    logic [1:0] m;
    int         n_mismatch = 0;
    int         checked = 0;
    int         n_tick = 0;
    int         seed = 26;
    always #5 ref_clk = ~ref_clk;
    eac_top #(.TICKS_ATOMIC(TA), .TICKS_SPLIT(TS)) i_eac_top (.ref_clk, .reset, .bus_addr,
        .bus_data_space, .bus_wr, .bus_rd, .bus_bit_op, .bus_bit_idx, .bus_wdata, .global_irq_en,
        .osc_tick, .mem_rdata, .bus_rdata, .bus_hit, .core_stall, .ready_irq, .mem_rd,
        .mem_addr, .mem_erase, .mem_write, .mem_wbyte);
    eac_array_model i_eac_array_model (.ref_clk, .mem_rd, .mem_addr, .mem_erase, .mem_write,
        .mem_wbyte, .osc_tick, .mem_rdata);
    always @(posedge ref_clk) if ((mem_erase | mem_write) && osc_tick) n_tick++;
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] pat(input logic [8:0] a);
        return a[7:0] ^ 8'hA5 ^ {7'h00, a[8]};
    endfunction
    task automatic stop_test();
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Core holds off while stalled; address form chosen at random except bit ops use I/O form
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w,
                       input logic bo = 1'b0, input logic [2:0] ix = 3'h0);
        logic ds;
        @(posedge ref_clk);
        #1;
        for (int i = 0; i < 8 && core_stall; i++) begin
            @(posedge ref_clk);
            #1;
        end
        if (core_stall !== 1'b0) begin
            n_mismatch++;
            $display("[ERR] %0t core stall never ended", $time);
            stop_test();
        end
        ds = bo ? 1'b0 : 1'($random(seed));
        bus_data_space = ds;
        bus_addr = ds ? a + 8'h20 : a;
        bus_wdata = d;
        bus_wr = w;
        bus_rd = !w;
        bus_bit_op = bo;
        bus_bit_idx = ix;
        @(posedge ref_clk);
        #1;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_bit_op = 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(a, d, 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
        acc(a, 8'h00, 1'b0);
        chk(bus_rdata, e, what);
        chk({7'h00, bus_hit}, {7'h00, (a >= 8'h1C) && (a <= 8'h1F)}, what);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 3000 && (mem_erase | mem_write); i++) @(posedge ref_clk);
        #1;
        if ((mem_erase | mem_write) !== 1'b0) begin
            n_mismatch++;
            $display("[ERR] %0t programming never ended", $time);
            stop_test();
        end
    endtask
    // mode loaded first, then address and data; reserved bits written zero
    task automatic prog(input logic [1:0] md, input logic [8:0] a, input logic [7:0] d);
        wr(8'h1C, {2'b00, md, 4'h0});
        wr(8'h1F, {7'h00, a[8]});
        wr(8'h1E, a[7:0]);
        wr(8'h1D, d);
        wr(8'h1C, {2'b00, md, 4'h4});
        wr(8'h1C, {2'b00, md, 4'h6});
        n_tick = 0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        rd(8'h1D, 8'h00, "data reset");
        rd(8'h1C, 8'h00, "control reset");
        rd(8'h1B, 8'h00, "unmapped read");
        rd(8'h3C, 8'h00, "reserved window read");
        wr(8'h1F, 8'hFF);
        rd(8'h1F, 8'h01, "high address bits");
        adr = 9'($random(seed));
        wr(8'h1F, {7'h00, adr[8]});
        wr(8'h1E, adr[7:0]);
        wr(8'h1C, 8'h01);
        rd(8'h1D, pat(adr), "read strobe");
        for (int k = 0; k < 3; k++) begin
            m = (k == 0) ? 2'h1 : (k == 1) ? 2'h2 : 2'h0;
            dat = 8'($random(seed));
            prog(m, adr, dat);
            wr(8'h1C, 8'h30);
            rd(8'h1C, {2'b00, m, 4'h2}, "mode while busy");
            wr(8'h1E, ~adr[7:0]);
            wr(8'h1C, 8'h01);
            rd(8'h1E, adr[7:0], "address while busy");
            rd(8'h1D, dat, "strobe while busy");
            wait_idle();
            chk(8'(n_tick), 8'((m == 2'h0) ? TA : TS), "tick count");
            wr(8'h1C, 8'h01);
            rd(8'h1D, (m == 2'h1) ? 8'hFF : dat, "array content");
        end
        wr(8'h1C, 8'h02);
        rd(8'h1C, 8'h00, "trigger without arm");
        wr(8'h1C, 8'h04);
        repeat (2) @(posedge ref_clk);
        wr(8'h1C, 8'h02);
        rd(8'h1C, 8'h02, "trigger on last arm cycle");
        wait_idle();
        wr(8'h1C, 8'h04);
        repeat (3) @(posedge ref_clk);
        wr(8'h1C, 8'h02);
        rd(8'h1C, 8'h00, "trigger after arm expiry");
        prog(2'h3, adr, 8'h00);
        repeat (4) @(posedge ref_clk);
        rd(8'h1C, 8'h30, "reserved mode trigger");
        wr(8'h1D, 8'h0F);
        acc(8'h1D, 8'h80, 1'b1, 1'b1, 3'h7);
        acc(8'h1D, 8'h00, 1'b1, 1'b1, 3'h0);
        rd(8'h1D, 8'h8E, "bit set and clear");
        global_irq_en = 1'b1;
        wr(8'h1C, 8'h08);
        chk({7'h00, ready_irq}, 8'h01, "ready request");
        global_irq_en = 1'b0;
        @(posedge ref_clk);
        #1;
        chk({7'h00, ready_irq}, 8'h00, "masked request");
        prog(2'h2, adr, 8'h3C);
        reset = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        chk({7'h00, mem_write}, 8'h01, "program survives reset");
        rd(8'h1C, 8'h22, "mode kept in reset");
        wait_idle();
        chk(8'(n_tick), 8'(TS), "ticks across reset");
        wr(8'h1C, 8'h01);
        rd(8'h1D, 8'h3C, "byte after reset");
        wr(8'h1C, 8'h38);
        reset = 1'b1;
        @(posedge ref_clk);
        #1;
        reset = 1'b0;
        rd(8'h1C, 8'h00, "idle reset clears mode");
        stop_test();
    end
endmodule
